// file: hdl/refresh_ctl_regs.vh
`ifndef REFRESH_CTL_REGS_VH
`define REFRESH_CTL_REGS_VH

// ==========================================================
// Register offsets (byte addresses)
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_ROW         8'h08
`define REG_DONE_MASK   8'h0c
`define REG_TIMING      8'h10
`define REG_MODE        8'h14
`define REG_COUNTS      8'h18

// ==========================================================
// Control register fields
`define CTRL_EXIT_SR_BIT    0
`define CTRL_CLR_CNT_BIT    1

// ==========================================================
// Mode register fields
`define MODE_RPST_BIT       7
`define MODE_WPRE_BIT       2

// ==========================================================
// Reset values
`define TIMING_RESET        32'h0000_0000
`define MODE_RESET          8'h00
`define ROW_RESET           16'h0000

// ==========================================================
// Command encodings on CA[5:0], first edge (CA3 high, CA0-2 and CA4 low, CA5 selects all-bank)
`define CA_REFRESH_MASK     5'h1f
`define CA_REFRESH_CODE     5'h08
`define CA_ALL_BANK_BIT     5

// ==========================================================
// Bus answer codes
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

// file: hdl/ca_sampler.v
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Link clock edge finder and command/address capture
module ca_sampler #(
    parameter CA_W = 6
) (
    input  wire            clk,        // System clock
    input  wire            rst_n,      // Synchronised reset
    input  wire            ck_pin,     // Link clock from controller
    input  wire            cs_pin,     // Chip select
    input  wire [CA_W-1:0] ca_pin,     // Command/address bus
    output reg             edge_seen,  // Pulse per rising link edge
    output reg             cs_at_edge, // Chip select at that edge
    output reg  [CA_W-1:0] ca_at_edge  // CA bus at that edge
);

    reg [1:0]      ck_sync;
    reg [1:0]      cs_sync;
    reg [CA_W-1:0] ca_meta;
    reg [CA_W-1:0] ca_sync;
    reg            ck_last;

    // Data passes the same two stages as the clock so they stay aligned
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ck_sync    <= 2'b00;
            cs_sync    <= 2'b00;
            ca_meta    <= {CA_W{1'b0}};
            ca_sync    <= {CA_W{1'b0}};
            ck_last    <= 1'b0;
            edge_seen  <= 1'b0;
            cs_at_edge <= 1'b0;
            ca_at_edge <= {CA_W{1'b0}};
        end else begin
            ck_sync    <= {ck_sync[0], ck_pin};
            cs_sync    <= {cs_sync[0], cs_pin};
            ca_meta    <= ca_pin;
            ca_sync    <= ca_meta;
            ck_last    <= ck_sync[1];
            edge_seen  <= ck_sync[1] & ~ck_last;
            cs_at_edge <= cs_sync[1];
            ca_at_edge <= ca_sync;
        end
    end

endmodule // ca_sampler

`default_nettype wire

// file: hdl/refresh_counter_core.v
`timescale 1ns/1ps
`default_nettype none
`include "refresh_ctl_regs.vh"

// Operation
// - Refresh decoded at first edge: CS high, CA0-2 low, CA3 high, CA4 low.
// - CA5 low at first edge means per-bank, high means all-bank.
// - Per-bank target bank taken from CA0..CA2 at the second edge.
// - Set of eight counts from first per-bank refresh after synchronisation.
// - Bank count clears on reset and on self-refresh exit, unless a per-bank refresh lands in that cycle.
// - All-bank refresh clears bank count and refreshes all banks at current row.
// - Any refresh after an all-bank refresh uses an incremented row.
// - Per-bank increments bank count 7 to 0; full set advances row.

module refresh_counter_core #(
    parameter BANKS = 8,
    parameter ROW_W = 16
) (
    input  wire        CLK_SYS,       // 200 MHz system clock
    input  wire        RST_N,         // Active-low async reset
    input  wire        CK_LINK,       // Link clock from controller
    input  wire        CS,            // Chip select pin
    input  wire [5:0]  CA,            // Command/address pins
    input  wire        AWVALID,       // AXI write address valid
    output wire        AWREADY,       // AXI write address ready
    input  wire [7:0]  AWADDR,        // AXI write address
    input  wire        WVALID,        // AXI write data valid
    output wire        WREADY,        // AXI write data ready
    input  wire [31:0] WDATA,         // AXI write data
    input  wire [3:0]  WSTRB,         // AXI byte strobes
    output reg         BVALID,        // AXI write response valid
    input  wire        BREADY,        // AXI write response ready
    output reg  [1:0]  BRESP,         // AXI write response
    input  wire        ARVALID,       // AXI read address valid
    output wire        ARREADY,       // AXI read address ready
    input  wire [7:0]  ARADDR,        // AXI read address
    output reg         RVALID,        // AXI read data valid
    input  wire        RREADY,        // AXI read data ready
    output reg  [31:0] RDATA,         // AXI read data
    output reg  [1:0]  RRESP,         // AXI read response
    output reg         REFRESH_PULSE, // One pulse per refresh performed
    output reg  [7:0]  REFRESH_BANKS, // Banks refreshed by that pulse
    output reg  [15:0] REFRESH_ROW    // Row used by that pulse
);

    // ==========================================================
    // Reset release
    reg [1:0] rst_pipe;
    wire      rst_n = rst_pipe[1];

    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    // ==========================================================
    // Link sampling
    wire       edge_seen;
    wire       cs_at_edge;
    wire [5:0] ca_at_edge;

    ca_sampler #(
        .CA_W (6)
    ) u_sampler (
        .clk        (CLK_SYS),
        .rst_n      (rst_n),
        .ck_pin     (CK_LINK),
        .cs_pin     (CS),
        .ca_pin     (CA),
        .edge_seen  (edge_seen),
        .cs_at_edge (cs_at_edge),
        .ca_at_edge (ca_at_edge)
    );

    function is_refresh;
        input       cs_v;
        input [5:0] ca_v;
        begin
            is_refresh = cs_v &&
                ((ca_v[4:0] & `CA_REFRESH_MASK) == `CA_REFRESH_CODE);
        end
    endfunction

    // ==========================================================
    // Registers
    reg [31:0]      timing_cfg;
    reg [7:0]       mode_cfg;
    reg [2:0]       bank_count;
    reg [ROW_W-1:0] row_count;
    reg             row_bump;
    reg [BANKS-1:0] done_mask;
    reg [15:0]      pb_total;
    reg [15:0]      ab_total;
    reg             sr_exit_req;

    // ==========================================================
    // Command decode state
    localparam ST_IDLE   = 1'b0;
    localparam ST_SECOND = 1'b1;

    reg state;

    wire first_hit = edge_seen && state == ST_IDLE && is_refresh(cs_at_edge, ca_at_edge);
    wire all_bank  = first_hit && ca_at_edge[`CA_ALL_BANK_BIT];
    wire per_bank  = edge_seen && state == ST_SECOND;
    wire [2:0] target_bank = ca_at_edge[2:0];

    // Row used by the current refresh, including a pending increment
    wire [ROW_W-1:0] row_now = row_bump ? row_count + 1'b1 : row_count;

    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (first_hit && !ca_at_edge[`CA_ALL_BANK_BIT]) begin
                        state <= ST_SECOND;
                    end
                end
                ST_SECOND: begin
                    if (edge_seen) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Bank and row counters
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            bank_count    <= 3'h0;
            row_count     <= {ROW_W{1'b0}};
            row_bump      <= 1'b0;
            done_mask     <= {BANKS{1'b0}};
            pb_total      <= 16'h0000;
            ab_total      <= 16'h0000;
            REFRESH_PULSE <= 1'b0;
            REFRESH_BANKS <= 8'h00;
            REFRESH_ROW   <= 16'h0000;
        end else begin
            REFRESH_PULSE <= 1'b0;
            if (all_bank) begin
                // Row stays after a partial set; next refresh advances it
                REFRESH_PULSE <= 1'b1;
                REFRESH_BANKS <= 8'hff;
                REFRESH_ROW   <= row_now[15:0];
                row_count     <= row_now;
                row_bump      <= 1'b1;
                bank_count    <= 3'h0;
                done_mask     <= {BANKS{1'b0}};
                ab_total      <= ab_total + 16'h0001;
            end else if (per_bank) begin
                REFRESH_PULSE <= 1'b1;
                REFRESH_BANKS <= 8'h01 << target_bank;
                REFRESH_ROW   <= row_now[15:0];
                pb_total      <= pb_total + 16'h0001;
                row_bump      <= 1'b0;
                bank_count    <= bank_count + 3'h1;
                if (bank_count == 3'h7) begin
                    // Set complete: following set uses the next row
                    row_count <= row_now + 1'b1;
                    done_mask <= {BANKS{1'b0}};
                end else begin
                    row_count <= row_now;
                    done_mask <= done_mask | (8'h01 << target_bank);
                end
            end else if (sr_exit_req) begin
                bank_count <= 3'h0;
                done_mask  <= {BANKS{1'b0}};
            end
        end
    end

    // ==========================================================
    // AXI4-Lite slave: address and data taken in either order
    reg        aw_held;
    reg [7:0]  aw_addr;
    reg        w_held;
    reg [31:0] w_data;
    reg [3:0]  w_strb;

    assign AWREADY = !aw_held && !BVALID;
    assign WREADY  = !w_held && !BVALID;
    assign ARREADY = !RVALID;

    wire do_write = aw_held && w_held && !BVALID;

    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  strb;
        integer i;
        begin
            merge = old_v;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
        end
    endfunction

    wire [31:0] mode_wide = merge({24'h000000, mode_cfg}, w_data, w_strb);

    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            aw_held     <= 1'b0;
            aw_addr     <= 8'h00;
            w_held      <= 1'b0;
            w_data      <= 32'h0000_0000;
            w_strb      <= 4'h0;
            BVALID      <= 1'b0;
            BRESP       <= `RESP_OKAY;
            timing_cfg  <= `TIMING_RESET;
            mode_cfg    <= `MODE_RESET;
            sr_exit_req <= 1'b0;
        end else begin
            sr_exit_req <= 1'b0;
            if (AWVALID && AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_held <= 1'b1;
                w_data <= WDATA;
                w_strb <= WSTRB;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                BVALID  <= 1'b1;
                BRESP   <= `RESP_OKAY;
                case (aw_addr)
                    `REG_CTRL: begin
                        // Self-refresh exit or software resync of bank count
                        if (w_strb[0] && (w_data[`CTRL_EXIT_SR_BIT] ||
                                          w_data[`CTRL_CLR_CNT_BIT])) begin
                            sr_exit_req <= 1'b1;
                        end
                    end
                    `REG_TIMING: timing_cfg <= merge(timing_cfg, w_data, w_strb);
                    `REG_MODE:   mode_cfg   <= mode_wide[7:0];
                    `REG_STATUS, `REG_ROW, `REG_DONE_MASK, `REG_COUNTS: begin
                        BRESP <= `RESP_OKAY;
                    end
                    default: BRESP <= `RESP_SLVERR;
                endcase
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Read path, answer one cycle after the address is taken
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            RVALID <= 1'b0;
            RDATA  <= 32'h0000_0000;
            RRESP  <= `RESP_OKAY;
        end else begin
            if (ARVALID && ARREADY) begin
                RVALID <= 1'b1;
                RRESP  <= `RESP_OKAY;
                case (ARADDR)
                    `REG_CTRL:      RDATA <= 32'h0000_0000;
                    `REG_STATUS:    RDATA <= {27'h0, row_bump, state, bank_count};
                    `REG_ROW:       RDATA <= {{(32-ROW_W){1'b0}}, row_count};
                    `REG_DONE_MASK: RDATA <= {24'h000000, done_mask};
                    `REG_TIMING:    RDATA <= timing_cfg;
                    `REG_MODE:      RDATA <= {24'h000000, mode_cfg};
                    `REG_COUNTS:    RDATA <= {ab_total, pb_total};
                    default: begin
                        RDATA <= 32'h0000_0000;
                        RRESP <= `RESP_SLVERR;
                    end
                endcase
            end else if (RVALID && RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end

endmodule // refresh_counter_core

`default_nettype wire

// file: tb/refresh_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module refresh_core_checker (
    input wire logic        CLK_SYS,       // Clock
    input wire logic        RST_N,         // Reset
    input wire logic        AWVALID,       // Bus
    input wire logic        AWREADY,       // Bus
    input wire logic        WVALID,        // Bus
    input wire logic        WREADY,        // Bus
    input wire logic        BVALID,        // Bus
    input wire logic        BREADY,        // Bus
    input wire logic [1:0]  BRESP,         // Bus
    input wire logic        ARVALID,       // Bus
    input wire logic        ARREADY,       // Bus
    input wire logic        RVALID,        // Bus
    input wire logic        RREADY,        // Bus
    input wire logic [31:0] RDATA,         // Bus
    input wire logic [1:0]  RRESP,         // Bus
    input wire logic        REFRESH_PULSE, // Result
    input wire logic [7:0]  REFRESH_BANKS, // Result
    input wire logic [15:0] REFRESH_ROW    // Result
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    logic [15:0] last_row;
    logic        last_all;
    // Row and kind of the previous refresh
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            last_row <= 16'h0000;
            last_all <= 1'b0;
        end else if (REFRESH_PULSE) begin
            last_row <= REFRESH_ROW;
            last_all <= (REFRESH_BANKS == 8'hff);
        end
    end
    a_pulse_single: assert property (REFRESH_PULSE |=> !REFRESH_PULSE)
        else $error("refresh pulse longer than one cycle");
    a_banks_shape: assert property (REFRESH_PULSE |->
        ($onehot(REFRESH_BANKS) || REFRESH_BANKS == 8'hff)) else $error("bad bank set");
    a_result_hold: assert property (!REFRESH_PULSE |->
        $stable(REFRESH_BANKS) && $stable(REFRESH_ROW)) else $error("result moved");
    a_row_after_all: assert property (REFRESH_PULSE && last_all |->
        REFRESH_ROW == last_row + 16'h0001) else $error("row not bumped after all-bank");
    a_row_step: assert property (REFRESH_PULSE |->
        REFRESH_ROW == last_row || REFRESH_ROW == last_row + 16'h0001)
        else $error("row jumped");
    a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
        else $error("no write response");
    a_bvalid_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped");
    a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("no read response");
    a_rvalid_hold: assert property (RVALID && !RREADY |=>
        RVALID && $stable(RDATA) && $stable(RRESP)) else $error("read data dropped");
    a_busy_refuse: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write taken while busy");
endmodule // refresh_core_checker
bind refresh_counter_core refresh_core_checker chk_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
    .REFRESH_PULSE(REFRESH_PULSE), .REFRESH_BANKS(REFRESH_BANKS),
    .REFRESH_ROW(REFRESH_ROW));
`default_nettype wire

// file: tb/mem_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Controller side of the command link
module mem_ctl_model (
    output logic       ck_link, // Link clock, still between frames
    output logic       cs,      // Chip select
    output logic [5:0] ca       // Command/address
);
    initial begin
        ck_link = 1'b0;
        cs = 1'b0;
        ca = 6'h00;
    end
    task automatic edge_out(input logic cs_v, input logic [5:0] ca_v);
        cs = cs_v;
        ca = ca_v;
        #32 ck_link = 1'b1;
        #32 ck_link = 1'b0;
    endtask
    // Caller keeps banks idle and unrepeated within a set
    task automatic send(input logic [5:0] first, input logic [5:0] second);
        edge_out(1'b1, first);
        edge_out(1'b0, second);
        ca = ~ca; // Released lines do not keep their value
    endtask
endmodule // mem_ctl_model
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "refresh_ctl_regs.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
    $display("Error %0t: got %h want %h", $time, (a), (e)); end end
module tb;
    logic        CLK_SYS, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic [7:0]  AWADDR, ARADDR;
    logic [31:0] WDATA, rd;
    logic [3:0]  WSTRB;
    logic [1:0]  rsp;
    wire         AWREADY, WREADY, BVALID, ARREADY, RVALID, REFRESH_PULSE, CK_LINK, CS;
    wire  [1:0]  BRESP, RRESP;
    wire  [31:0] RDATA;
    wire  [7:0]  REFRESH_BANKS;
    wire  [15:0] REFRESH_ROW;
    wire  [5:0]  CA;
    int          mismatches, checks, pulses, cnt;
    // Expected row in the high nibble, bank or all-bank (8) below
    localparam logic [7:0] ROWS [22] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
        8'h06, 8'h07, 8'h16, 8'h17, 8'h11, 8'h13, 8'h15, 8'h12, 8'h10, 8'h14, 8'h20,
        8'h21, 8'h22, 8'h28, 8'h36, 8'h37};
    localparam logic [5:0] BAD [4] = '{6'h09, 6'h0a, 6'h0c, 6'h18};
    refresh_counter_core dut_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CK_LINK(CK_LINK),
        .CS(CS), .CA(CA), .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
        .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB), .BVALID(BVALID),
        .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
        .REFRESH_PULSE(REFRESH_PULSE), .REFRESH_BANKS(REFRESH_BANKS),
        .REFRESH_ROW(REFRESH_ROW));
    mem_ctl_model ctl_u (.ck_link(CK_LINK), .cs(CS), .ca(CA));
    initial begin
        CLK_SYS = 1'b0;
        forever #2.5 CLK_SYS = ~CLK_SYS;
    end
    always @(posedge CLK_SYS) if (REFRESH_PULSE === 1'b1) pulses++;
    // ==========
    // Bus and link tasks
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge CLK_SYS);
        {AWVALID, WVALID, BREADY, AWADDR, WDATA, WSTRB} <= {3'b111, a, d, 4'hf};
        forever begin
            @(posedge CLK_SYS);
            if (AWVALID && AWREADY) AWVALID <= 1'b0;
            if (WVALID && WREADY) WVALID <= 1'b0;
            if (BVALID && BREADY) break;
        end
        r = BRESP;
        BREADY <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge CLK_SYS);
        {ARVALID, RREADY, ARADDR} <= {2'b11, a};
        forever begin
            @(posedge CLK_SYS);
            if (ARVALID && ARREADY) ARVALID <= 1'b0;
            if (RVALID && RREADY) break;
        end
        d = RDATA;
        r = RRESP;
        RREADY <= 1'b0;
    endtask
    // Bank and row results hold, so they are read after the frame
    task automatic refr(input logic [3:0] c);
        int p;
        p = pulses;
        ctl_u.send(c[3] ? 6'h28 : 6'h08, {3'b000, c[2:0]});
        repeat (8) @(posedge CLK_SYS);
        `CHK(pulses, p + 1)
        `CHK(REFRESH_BANKS, c[3] ? 8'hff : 8'h01 << c[2:0])
    endtask
    task automatic summarize;
        if (mismatches == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        summarize();
    end
    // ==========
    // Main sequence
    initial begin
        {AWVALID, WVALID, BREADY, ARVALID, RREADY, RST_N} = 6'h00;
        {AWADDR, ARADDR, WDATA, WSTRB} = 52'h0;
        repeat (8) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        repeat (4) @(posedge CLK_SYS);
        axr(`REG_TIMING, rd, rsp);
        `CHK(rd, `TIMING_RESET)
        axr(`REG_MODE, rd, rsp);
        `CHK(rd, {24'h0, `MODE_RESET})
        foreach (ROWS[i]) begin // Sets never repeat a bank
            refr(ROWS[i][3:0]);
            cnt = ROWS[i][3] ? 0 : (cnt + 1) % 8;
            `CHK(REFRESH_ROW, {12'h000, ROWS[i][7:4]})
            axr(`REG_STATUS, rd, rsp);
            `CHK(rd[2:0], cnt[2:0])
        end
        foreach (BAD[i]) ctl_u.send(BAD[i], 6'h00);
        repeat (8) @(posedge CLK_SYS);
        `CHK(pulses, 22)
        refr(4'h3);
        axw(`REG_CTRL, 32'h1, rsp);
        axr(`REG_STATUS, rd, rsp);
        `CHK(rd[2:0], 3'h0)
        refr(4'h3); // Legal again once the count restarts
        axr(`REG_STATUS, rd, rsp);
        `CHK(rd[2:0], 3'h1)
        axr(`REG_DONE_MASK, rd, rsp);
        `CHK(rd, 32'h0000_0008)
        axw(`REG_CTRL, 32'h2, rsp);
        axr(`REG_STATUS, rd, rsp);
        `CHK(rd[2:0], 3'h0)
        axr(`REG_DONE_MASK, rd, rsp);
        `CHK(rd, 32'h0000_0000)
        axr(`REG_COUNTS, rd, rsp);
        `CHK(rd, 32'h0001_0017)
        axw(8'h40, 32'h1, rsp);
        `CHK(rsp, `RESP_SLVERR)
        axr(8'h40, rd, rsp);
        `CHK({rd, rsp}, {32'h0, `RESP_SLVERR})
        axw(`REG_TIMING, 32'ha5a5_5a5a, rsp);
        axr(`REG_TIMING, rd, rsp);
        `CHK({rd, rsp}, {32'ha5a5_5a5a, `RESP_OKAY})
        axw(`REG_MODE, 32'h0000_0084, rsp);
        axr(`REG_MODE, rd, rsp);
        `CHK(rd, 32'h0000_0084)
        axw(`REG_ROW, 32'h0000_ffff, rsp);
        axr(`REG_ROW, rd, rsp);
        `CHK(rd, 32'h0000_0003)
        RST_N <= 1'b0;
        repeat (8) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        repeat (4) @(posedge CLK_SYS);
        `CHK(REFRESH_BANKS, 8'h00)
        axr(`REG_STATUS, rd, rsp);
        `CHK(rd[2:0], 3'h0)
        axr(`REG_ROW, rd, rsp);
        `CHK(rd, {16'h0, `ROW_RESET})
        summarize();
    end
endmodule // tb
`default_nettype wire
